// [hw/bk3cfg_bank.sv]
// Register bank and control decode for the third step-down regulator.
`timescale 1ns/10ps
module bk3cfg_bank (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Register port from the serial target.
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Enable register fields and system state.
	input wire logic [2:0] reg3_sequencing_field_i,
	input wire logic [1:0] reg3_enable_field_i,
	input wire logic boot_step_done_i,
	input wire logic hard_reset_i,
	input wire logic [6:0] reg3_voltage_step_i,
	// Multi-purpose pins, asynchronous.
	input wire logic [7:0] multipurpose_pin_i,
	// Controls to the regulator.
	output bk3cfg_pkg::bk3cfg_ctrl_t ctrl_o
);

	bk3cfg_pkg::bk3cfg_state_t state_reg;
	bk3cfg_pkg::bk3cfg_state_t state_next;

	// Applies a write mask so unused bits stay zero.
	function automatic logic [7:0] masked(input logic [7:0] d,
		input logic [7:0] m);
		masked = d & m;
	endfunction

	// Next state: register writes, read data, pin sync and control decode.
	// Controls are built from the current registers, so they follow a write
	// by one cycle; this keeps every output on a flip-flop.
	always_comb begin
		logic [7:0] sel_pins;
		logic seq_early;
		logic [1:0] en_f;
		logic [2:0] seq_f;
		state_next = state_reg;
		sel_pins = state_reg.pin_sync & state_reg.regs.pins;
		en_f = reg3_enable_field_i;
		seq_f = reg3_sequencing_field_i;
		seq_early = (seq_f >= bk3cfg_pkg::SEQ_EARLY_LO) &&
			(seq_f <= bk3cfg_pkg::SEQ_EARLY_HI);
		state_next.pin_meta = multipurpose_pin_i;
		state_next.pin_sync = state_reg.pin_meta;
		if (reg_wr_i) begin
			case (reg_addr_i)
				bk3cfg_pkg::ADDR_CFG_A: state_next.regs.cfg_a =
					masked(reg_wdata_i, bk3cfg_pkg::MASK_CFG_A);
				bk3cfg_pkg::ADDR_CFG_B: state_next.regs.cfg_b =
					masked(reg_wdata_i, bk3cfg_pkg::MASK_CFG_B);
				bk3cfg_pkg::ADDR_PEAK: state_next.regs.peak =
					masked(reg_wdata_i, bk3cfg_pkg::MASK_PEAK);
				bk3cfg_pkg::ADDR_VOUT: state_next.regs.vout =
					masked(reg_wdata_i, bk3cfg_pkg::MASK_VOUT);
				bk3cfg_pkg::ADDR_PINS: state_next.regs.pins =
					masked(reg_wdata_i, bk3cfg_pkg::MASK_PINS);
				default: state_next.regs = state_reg.regs;
			endcase
		end
		// Unmapped addresses read as zero.
		if (reg_rd_i) begin
			case (reg_addr_i)
				bk3cfg_pkg::ADDR_CFG_A: state_next.rd_data = state_reg.regs.cfg_a;
				bk3cfg_pkg::ADDR_CFG_B: state_next.rd_data = state_reg.regs.cfg_b;
				bk3cfg_pkg::ADDR_PEAK: state_next.rd_data = state_reg.regs.peak;
				bk3cfg_pkg::ADDR_VOUT: state_next.rd_data = state_reg.regs.vout;
				bk3cfg_pkg::ADDR_PINS: state_next.rd_data = state_reg.regs.pins;
				default: state_next.rd_data = 8'h00;
			endcase
		end
		// Enable decode; pins only count under pin control, ORed together.
		if ((seq_f == bk3cfg_pkg::SEQ_PIN_CTL) &&
			(en_f == bk3cfg_pkg::EN_PINS)) begin
			state_next.ctrl.enable = |sel_pins;
		end else if (seq_f == bk3cfg_pkg::SEQ_PIN_CTL) begin
			state_next.ctrl.enable = (en_f == bk3cfg_pkg::EN_ON);
		end else begin
			state_next.ctrl.enable = seq_early & boot_step_done_i;
		end
		// Discharge always in hard reset, optionally while disabled.
		state_next.ctrl.passive_dsc = hard_reset_i |
			(state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_PSV_DSC] &
			~state_reg.ctrl.enable);
		state_next.ctrl.active_dsc = hard_reset_i |
			(state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_ACT_DSC] &
			~state_reg.ctrl.enable);
		state_next.ctrl.slow_edge =
			state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_SLOW_EDGE];
		state_next.ctrl.transistor_halving =
			state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_HALVING];
		// Software must leave this clear for outputs at or below 1.6 V.
		state_next.ctrl.freewheel_sense =
			state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_LX_SENSE];
		state_next.ctrl.integrator_dis =
			state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_INTEG_DIS];
		state_next.ctrl.pgood_ena =
			state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_PGOOD_ENA];
		// Fast mode trades quiescent current for transient response.
		if (state_reg.regs.cfg_b[bk3cfg_pkg::CFGB_PIN4_FAST]) begin
			state_next.ctrl.fast_mode =
				state_reg.pin_sync[bk3cfg_pkg::PIN_FOUR];
		end else begin
			state_next.ctrl.fast_mode =
				state_reg.regs.cfg_a[bk3cfg_pkg::CFGA_FAST];
		end
		state_next.ctrl.dropout_fallback_dis =
			state_reg.regs.cfg_b[bk3cfg_pkg::CFGB_LDO_DIS];
		state_next.ctrl.forced_pwm =
			state_reg.regs.cfg_b[bk3cfg_pkg::CFGB_FPWM];
		// The fixed code applies only with adaptive off and table bypassed.
		state_next.ctrl.peak_fixed =
			state_reg.regs.cfg_b[bk3cfg_pkg::CFGB_ADPT_DIS] &
			state_reg.regs.peak[bk3cfg_pkg::PEAK_TABLE_BYP];
		state_next.ctrl.peak_ma = 9'(state_reg.regs.peak[3:0] *
			bk3cfg_pkg::PEAK_STEP_MA);
		state_next.ctrl.vout_mv = 12'(bk3cfg_pkg::VOUT_BASE_MV +
			12'(state_reg.regs.vout[5:0] * reg3_voltage_step_i));
	end

	// State register; everything clears to zero on reset.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_o = state_reg.rd_data;
	assign ctrl_o = state_reg.ctrl;

	// Checks on the write, read and decode paths.
	sequence wr_cfg_b_s;
		reg_wr_i && reg_addr_i == bk3cfg_pkg::ADDR_CFG_B;
	endsequence

	sequence rd_cfg_b_s;
		reg_rd_i && !reg_wr_i && reg_addr_i == bk3cfg_pkg::ADDR_CFG_B;
	endsequence

	unused_bits_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_cfg_b_s ##2 rd_cfg_b_s |=> reg_rdata_o[7] == 1'b0 &&
		reg_rdata_o[2:0] == 3'h0)
		else $error("Unused config bits read back nonzero.");

	peak_readback_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == bk3cfg_pkg::ADDR_PEAK ##2 reg_rd_i &&
		!reg_wr_i && reg_addr_i == bk3cfg_pkg::ADDR_PEAK |=>
		reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h8f))
		else $error("Peak register readback mismatch.");

	pin_enable_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg3_sequencing_field_i == 3'h7 && reg3_enable_field_i == 2'h2 |=>
		ctrl_o.enable == |($past(state_reg.pin_sync & state_reg.regs.pins)))
		else $error("Pin controlled enable is wrong.");

	pin_ignored_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg3_sequencing_field_i != 3'h7 && reg3_enable_field_i == 2'h2 &&
		!boot_step_done_i |=> !ctrl_o.enable)
		else $error("Pins acted outside pin control.");

	passive_dsc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hard_reset_i |=> ctrl_o.passive_dsc && ctrl_o.active_dsc)
		else $error("No discharge during hard reset.");

	active_dsc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hard_reset_i && !state_reg.regs.cfg_a[3] |=> !ctrl_o.active_dsc)
		else $error("Active discharge outside hard reset.");

	peak_fixed_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ctrl_o.peak_fixed |-> $past(state_reg.regs.peak[7]) &&
		$past(state_reg.regs.cfg_b[3]))
		else $error("Fixed peak without bypass and adaptive off.");

	peak_scale_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.regs.peak[3:0] == 4'hf ##1 state_reg.regs.peak[3:0] == 4'hf
		|-> ctrl_o.peak_ma == 9'h177)
		else $error("Peak current scaling wrong.");

	fast_pin_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.regs.cfg_b[5] |=> ctrl_o.fast_mode ==
		$past(state_reg.pin_sync[4]))
		else $error("Fast mode does not follow pin four.");

	edge_cfg_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == bk3cfg_pkg::ADDR_CFG_A ##2 1 |->
		ctrl_o.slow_edge == $past(reg_wdata_i[2], 2) &&
		ctrl_o.forced_pwm == $past(state_reg.regs.cfg_b[4]))
		else $error("Config controls did not follow the write.");

	vout_base_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.regs.vout == 8'h00 |=> ctrl_o.vout_mv == 12'h226)
		else $error("Zero code is not 550 mV.");

endmodule

// [hw/bk3cfg_pkg.sv]
// Constants and types for the third step-down regulator register bank.
// How it works
// - Config A bit 4: passive discharge in hard reset, or also when disabled.
// - Config A bit 3: active discharge in hard reset, or also when disabled.
// - Config A bit 2 slows switch-node edges threefold.
// - Config A bit 1 halves the power transistor size.
// - Config A bit 0 makes freewheel entry also wait for high switch node.
// - Config B bit 6 disables low-dropout fallback at low ratios.
// - Config B bit 5 lets pin four drive fast transient mode.
// - Config B bit 4 forces continuous pulse-width modulation.
// - Config B bit 3 fixes peak current at the code instead of adaptive.
// - Peak register bit 7 bypasses the table; only then the code applies.
// - Voltage code bits 5:0; output is 550 mV plus code times step.
// - Pin selection acts only when sequencing is 111 and enable is 10.
// - With several pins selected, enable is the OR of them.
// - Fast mode raises quiescent current for better transient response.
package bk3cfg_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_CFG_A = 8'h35;
	localparam logic [7:0] ADDR_CFG_B = 8'h36;
	localparam logic [7:0] ADDR_PEAK = 8'h37;
	localparam logic [7:0] ADDR_VOUT = 8'h38;
	localparam logic [7:0] ADDR_PINS = 8'h39;

	// Writable bit masks; all other bits hold zero.
	localparam logic [7:0] MASK_CFG_A = 8'hff;
	localparam logic [7:0] MASK_CFG_B = 8'h78;
	localparam logic [7:0] MASK_PEAK = 8'h8f;
	localparam logic [7:0] MASK_VOUT = 8'h3f;
	localparam logic [7:0] MASK_PINS = 8'hff;

	// Field positions in config A.
	localparam int CFGA_INTEG_DIS = 7;
	localparam int CFGA_PGOOD_ENA = 6;
	localparam int CFGA_FAST = 5;
	localparam int CFGA_PSV_DSC = 4;
	localparam int CFGA_ACT_DSC = 3;
	localparam int CFGA_SLOW_EDGE = 2;
	localparam int CFGA_HALVING = 1;
	localparam int CFGA_LX_SENSE = 0;
	// Field positions in config B.
	localparam int CFGB_LDO_DIS = 6;
	localparam int CFGB_PIN4_FAST = 5;
	localparam int CFGB_FPWM = 4;
	localparam int CFGB_ADPT_DIS = 3;
	// Field positions in the peak register and the multi-purpose pins.
	localparam int PEAK_TABLE_BYP = 7;
	localparam int PIN_FOUR = 4;

	// Reset values of every register.
	localparam logic [7:0] RST_VAL = 8'h00;

	// Enable decode values.
	localparam logic [2:0] SEQ_PIN_CTL = 3'h7;
	localparam logic [2:0] SEQ_EARLY_LO = 3'h2;
	localparam logic [2:0] SEQ_EARLY_HI = 3'h4;
	localparam logic [1:0] EN_ON = 2'h1;
	localparam logic [1:0] EN_PINS = 2'h2;

	// Analog scaling.
	localparam logic [8:0] PEAK_STEP_MA = 9'h019;
	localparam logic [11:0] VOUT_BASE_MV = 12'h226;

	// Register contents.
	typedef struct packed {
		logic [7:0] cfg_a;
		logic [7:0] cfg_b;
		logic [7:0] peak;
		logic [7:0] vout;
		logic [7:0] pins;
	} bk3cfg_regs_t;

	// Controls handed to the analog regulator.
	typedef struct packed {
		logic enable;
		logic passive_dsc;
		logic active_dsc;
		logic slow_edge;
		logic transistor_halving;
		logic freewheel_sense;
		logic integrator_dis;
		logic pgood_ena;
		logic fast_mode;
		logic dropout_fallback_dis;
		logic forced_pwm;
		logic peak_fixed;
		logic [8:0] peak_ma;
		logic [11:0] vout_mv;
	} bk3cfg_ctrl_t;

	// Whole state of the bank.
	typedef struct packed {
		bk3cfg_regs_t regs;
		logic [7:0] pin_meta;
		logic [7:0] pin_sync;
		logic [7:0] rd_data;
		bk3cfg_ctrl_t ctrl;
	} bk3cfg_state_t;

endpackage

// [testbench/bk3cfg_host.sv]
// Host model that drives the register port of the regulator-3 bank.
`timescale 1ns/10ps
module bk3cfg_host (
	// Clock.
	input wire logic clock_i,
	// Register port toward the bank.
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	// The port is quiet from time zero.
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'h00;
	end

	// One strobe across one rising edge; released lines are inverted so
	// that no stale value can pass for a driven one.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clock_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	// Read data is registered, so it is taken one cycle after the strobe.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clock_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		@(negedge clock_i);
		d = reg_rdata_i;
	endtask

	// Fixed peak code; callers keep it in the efficient window.
	task automatic set_peak(input logic [3:0] code);
		wr_reg(bk3cfg_pkg::ADDR_PEAK, {4'h8, code});
	endtask
endmodule

// [testbench/tb_buck3_config_registers.sv]
// Self-checking testbench for the regulator-3 register bank.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_buck3_config_registers;
	logic clock, sys_rst, hard_rst;
	logic [2:0] seq;
	logic [1:0] en;
	logic [6:0] step;
	logic [7:0] mpins, addr, wdata, rdata, rd_val;
	logic wr, rd;
	int failures, n_tests;
	bk3cfg_pkg::bk3cfg_ctrl_t ctrl;
	// Rows: address, written byte, expected readback.
	localparam logic [23:0] ROWS [10] = '{24'h35ffff, 24'h36ff78,
		24'h37ff8f, 24'h38ff3f, 24'h39ffff, 24'h3aff00, 24'h348700,
		24'h368700, 24'h377000, 24'h38c000};

	bk3cfg_host host (.clock_i(clock), .reg_addr_o(addr), .reg_wr_o(wr),
		.reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
	bk3cfg_bank uut (.clock_i(clock), .sys_rst_i(sys_rst),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg3_sequencing_field_i(seq), .reg3_enable_field_i(en),
		.boot_step_done_i(1'b0), .hard_reset_i(hard_rst),
		.reg3_voltage_step_i(step), .multipurpose_pin_i(mpins),
		.ctrl_o(ctrl));

	// Verdict and end of run.
	task automatic stop_test();
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Write, then let the pin synchroniser and control stage settle.
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		host.wr_reg(a, d);
		repeat (4) @(negedge clock);
	endtask

	// Free-running 250 MHz clock.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// A hung handshake must not stall the run forever.
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		stop_test();
	end

	// Main sequence: reset, table rows, then control decode cases.
	initial begin
		sys_rst = 1'b1;
		hard_rst = 1'b0;
		seq = 3'h0;
		en = 2'h0;
		step = 7'h32;
		mpins = 8'h00;
		failures = 0;
		n_tests = 0;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			host.rd_reg(8'h35 + 8'(i), rd_val);
			`CHK(rd_val, bk3cfg_pkg::RST_VAL)
		end
		foreach (ROWS[i]) begin
			host.wr_reg(ROWS[i][23:16], ROWS[i][15:8]);
			host.rd_reg(ROWS[i][23:16], rd_val);
			`CHK(rd_val, ROWS[i][7:0])
		end
		// Discharge and edge controls with the regulator disabled.
		put(8'h35, 8'h07);
		`CHK({ctrl.slow_edge, ctrl.transistor_halving}, 2'h3)
		`CHK(ctrl.freewheel_sense, 1'b1)
		`CHK({ctrl.passive_dsc, ctrl.active_dsc}, 2'h0)
		put(8'h35, 8'h10);
		`CHK({ctrl.passive_dsc, ctrl.active_dsc}, 2'h2)
		put(8'h35, 8'h08);
		`CHK({ctrl.passive_dsc, ctrl.active_dsc}, 2'h1)
		hard_rst = 1'b1;
		put(8'h35, 8'h00);
		`CHK({ctrl.passive_dsc, ctrl.active_dsc}, 2'h3)
		hard_rst = 1'b0;
		// Mode bits and peak current; the fixed peak needs both bits.
		put(8'h36, 8'h78);
		`CHK({ctrl.dropout_fallback_dis, ctrl.forced_pwm}, 2'h3)
		`CHK(ctrl.peak_fixed, 1'b0)
		host.set_peak(4'h7);
		repeat (4) @(negedge clock);
		`CHK(ctrl.peak_fixed, 1'b1)
		`CHK(ctrl.peak_ma, 9'h0af)
		put(8'h36, 8'h00);
		`CHK(ctrl.peak_fixed, 1'b0)
		// Top code at a 50 mV step gives 3700 mV.
		put(8'h38, 8'h3f);
		`CHK(ctrl.vout_mv, 12'he74)
		// Pins 6 and 4 selected; pin 7 alone must not enable.
		put(8'h39, 8'h50);
		seq = 3'h7;
		en = 2'h2;
		mpins = 8'h80;
		repeat (4) @(negedge clock);
		`CHK(ctrl.enable, 1'b0)
		mpins = 8'h40;
		repeat (4) @(negedge clock);
		`CHK(ctrl.enable, 1'b1)
		seq = 3'h0;
		repeat (4) @(negedge clock);
		`CHK(ctrl.enable, 1'b0)
		// Fast mode from config A, then handed to pin four.
		put(8'h35, 8'h20);
		`CHK(ctrl.fast_mode, 1'b1)
		mpins = 8'h00;
		put(8'h36, 8'h20);
		`CHK(ctrl.fast_mode, 1'b0)
		mpins = 8'h10;
		repeat (4) @(negedge clock);
		`CHK(ctrl.fast_mode, 1'b1)
		stop_test();
	end
endmodule
